/* File: rtl/dqvref_decode.sv */
// dq reference training register decode and reference level generation
// Notes on behaviour
// - value steps 0.65 percent from 60 or 45
// - bit 6 picks range one or two
// - select code 111 command silently ignored
// - device generates reference level from range, value
// - spare register writes change nothing
`timescale 1ns/1ps
`default_nettype none
`include "dqvref_defines.svh"
module dqvref_decode import dqvref_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire dqvref_cmd_type cmd,
	output var dqvref_cfg_type cfg,
	output logic [15:0] ref_level_bp,
	output logic ref_valid,
	output logic training_active,
	output logic [3:0] spacing_nck
);
	dqvref_cfg_type cfg_q;
	logic [15:0] level_q;
	logic valid_q;
	logic hit_training;
	logic hit_reserved;
	logic hit_other;
	logic [2:0] op_spacing;
	logic [15:0] base_bp;
	logic [15:0] level_d;
	logic level_ok_d;
	logic [3:0] nck_q;
	logic [1:0] since_wr_q;

	// only the training register select is accepted; 111 and spare fall out
	assign hit_training = cmd.mrs && (cmd.sel == `DQVREF_SEL_TRAINING);
	// select 111 is kept for register control words and doubles as the spare register
	assign hit_reserved = cmd.mrs && (cmd.sel == `DQVREF_SEL_RCW);
	// any other select belongs to a mode register outside this block
	assign hit_other = cmd.mrs && !hit_training && !hit_reserved;
	// spacing code as it stands on A12..A10
	assign op_spacing = cmd.op[`DQVREF_SPACING_LSB +: 3];

	// register update on a training register write
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cfg_q <= '{spacing: `DQVREF_RST_SPACING, train_en: `DQVREF_RST_TRAIN,
				range_sel: `DQVREF_RST_RANGE, value: `DQVREF_RST_VALUE};
		end else if (hit_training) begin
			cfg_q.value <= cmd.op[`DQVREF_VALUE_LSB +: 6];
			cfg_q.range_sel <= cmd.op[`DQVREF_RANGE_BIT];
			cfg_q.train_en <= cmd.op[`DQVREF_TRAIN_BIT];
			cfg_q.spacing <= cmd.op[`DQVREF_SPACING_LSB +: 3];
		end
	end

	// spacing in clocks, kept in a flop beside the field; codes 5..7 reserved but passed on
	always_ff @(posedge clk) begin
		if (!nrst) begin
			nck_q <= `DQVREF_SPACING_MIN_NCK + {1'b0, `DQVREF_RST_SPACING};
		end else if (hit_training) begin
			nck_q <= `DQVREF_SPACING_MIN_NCK + {1'b0, op_spacing};
		end
	end

	// linear level in hundredths of a percent of the io supply
	always_comb begin
		base_bp = cfg_q.range_sel ? `DQVREF_BASE_R2_BP : `DQVREF_BASE_R1_BP;
		level_d = base_bp + 16'(cfg_q.value * `DQVREF_STEP_BP);
		level_ok_d = (cfg_q.value < `DQVREF_FIRST_RESERVED);
	end

	// registered reference level; reserved codes read as zero and invalid
	always_ff @(posedge clk) begin
		if (!nrst) begin
			level_q <= 16'h0000;
			valid_q <= 1'b0;
		end else begin
			level_q <= level_ok_d ? level_d : 16'h0000;
			valid_q <= level_ok_d;
		end
	end

	// cycles since the last accepted write, saturating; reset counts as a write
	always_ff @(posedge clk) begin
		if (!nrst) begin
			since_wr_q <= 2'h0;
		end else if (hit_training) begin
			since_wr_q <= 2'h0;
		end else if (since_wr_q != 2'h3) begin
			since_wr_q <= since_wr_q + 2'h1;
		end
	end

	// outputs straight from the flops
	assign cfg = cfg_q;
	assign ref_level_bp = level_q;
	assign ref_valid = valid_q;
	assign training_active = cfg_q.train_en;
	assign spacing_nck = nck_q;

	// write to training register lands next cycle
	a_write_lands: assert property (@(posedge clk) disable iff (!nrst)
		hit_training |=> cfg.value == $past(cmd.op[5:0]))
		else $error("value field not stored");

	// select 111 leaves config untouched
	a_rcw_ignored: assert property (@(posedge clk) disable iff (!nrst)
		cmd.mrs && cmd.sel == `DQVREF_SEL_RCW |=> $stable(cfg))
		else $error("reserved select changed config");

	// no training write, no config change
	a_spare_ignored: assert property (@(posedge clk) disable iff (!nrst)
		!hit_training |=> $stable(cfg))
		else $error("config changed without training write");

	// range one level tracks value two cycles after write
	a_range1_level: assert property (@(posedge clk) disable iff (!nrst)
		hit_training && !cmd.op[6] && cmd.op[5:0] < 6'h33 ##1 !hit_training |=>
		ref_level_bp == 16'h1770 + 16'h0041 * 16'($past(cfg.value)))
		else $error("range one level wrong");

	// range two base level
	a_range2_base: assert property (@(posedge clk) disable iff (!nrst)
		hit_training && cmd.op[6:0] == 7'h40 ##1 !hit_training |=>
		ref_level_bp == 16'h1194)
		else $error("range two base wrong");

	// reserved codes never valid
	a_reserved_code: assert property (@(posedge clk) disable iff (!nrst)
		hit_training && cmd.op[5:0] >= 6'h33 ##1 !hit_training |=> !ref_valid)
		else $error("reserved code reported valid");

	// level stays inside the two windows
	a_level_window: assert property (@(posedge clk) disable iff (!nrst)
		ref_valid |-> ref_level_bp >= 16'h1194 && ref_level_bp <= 16'h2422)
		else $error("level outside window");

	// enable and spacing follow A7 and A12..A10
	a_fields_map: assert property (@(posedge clk) disable iff (!nrst)
		hit_training |=> training_active == $past(cmd.op[7]) &&
		cfg.spacing == $past(cmd.op[12:10]))
		else $error("enable or spacing misplaced");

	// reset clears every field and both level outputs
	a_reset_clears: assert property (@(posedge clk)
		!nrst |=> cfg == '0 && !training_active && spacing_nck == 4'h4 &&
		!ref_valid && ref_level_bp == 16'h0000)
		else $error("reset left a field set");

	// range select follows A6
	a_range_stored: assert property (@(posedge clk) disable iff (!nrst)
		hit_training |=> cfg.range_sel == $past(cmd.op[6]))
		else $error("range select not stored");

	// spare register write leaves config and spacing untouched
	a_spare_select: assert property (@(posedge clk) disable iff (!nrst)
		cmd.mrs && cmd.sel == `DQVREF_SEL_SPARE |=> $stable(cfg) && $stable(spacing_nck))
		else $error("spare write changed config");

	// no command, no change
	a_idle_select: assert property (@(posedge clk) disable iff (!nrst)
		!cmd.mrs |=> $stable(cfg) && $stable(spacing_nck))
		else $error("config changed without command");

	// other mode registers do not touch this block
	a_other_ignored: assert property (@(posedge clk) disable iff (!nrst)
		hit_other |=> $stable(cfg) && $stable(spacing_nck))
		else $error("other select changed config");

	// spacing clocks are four plus the code
	a_spacing_clocks: assert property (@(posedge clk) disable iff (!nrst)
		hit_training |=> spacing_nck == 4'h4 + {1'b0, $past(cmd.op[12:10])})
		else $error("spacing clocks wrong");

	// valid flag follows the stored code once settled
	a_valid_tracks: assert property (@(posedge clk) disable iff (!nrst)
		since_wr_q != 2'h0 |-> ref_valid == (cfg.value < 6'h33))
		else $error("valid flag disagrees with code");

	// an invalid level reads as zero
	a_invalid_zero: assert property (@(posedge clk) disable iff (!nrst)
		!ref_valid |-> ref_level_bp == 16'h0000)
		else $error("invalid level not zero");

	// range two level tracks value two cycles after write
	a_range2_level: assert property (@(posedge clk) disable iff (!nrst)
		hit_training && cmd.op[6] && cmd.op[5:0] < 6'h33 ##1 !hit_training |=>
		ref_level_bp == 16'h1194 + 16'h0041 * 16'($past(cfg.value)))
		else $error("range two level wrong");

	// settled level matches range base plus steps
	a_level_settled: assert property (@(posedge clk) disable iff (!nrst)
		since_wr_q != 2'h0 && ref_valid |-> ref_level_bp ==
		(cfg.range_sel ? 16'h1194 : 16'h1770) + 16'h0041 * 16'(cfg.value))
		else $error("settled level wrong");

	// level holds while nothing is written
	a_level_hold: assert property (@(posedge clk) disable iff (!nrst)
		!hit_training ##1 !hit_training |=> $stable(ref_level_bp) && $stable(ref_valid))
		else $error("level moved without write");

	// top code of range two gives 77.5 percent
	a_range2_top: assert property (@(posedge clk) disable iff (!nrst)
		hit_training && cmd.op[6:0] == 7'h72 ##1 !hit_training |=> ref_level_bp == 16'h1e46)
		else $error("range two top wrong");

	// training enable holds between writes
	a_enable_hold: assert property (@(posedge clk) disable iff (!nrst)
		!hit_training |=> $stable(training_active))
		else $error("training enable moved");

	// select 111 leaves the level and its flag alone
	a_rcw_level: assert property (@(posedge clk) disable iff (!nrst)
		cmd.mrs && cmd.sel == `DQVREF_SEL_RCW |=>
		##1 $stable(ref_level_bp) && $stable(ref_valid))
		else $error("reserved select moved the level");

	// reserved codes read as a zero level
	a_reserved_level: assert property (@(posedge clk) disable iff (!nrst)
		hit_training && cmd.op[5:0] >= 6'h33 ##1 !hit_training |=> ref_level_bp == 16'h0000)
		else $error("reserved code gave a level");
endmodule
`default_nettype wire

/* File: rtl/dqvref_defines.svh */
// constants for the dq reference training register decode
`ifndef DQVREF_DEFINES_SVH
`define DQVREF_DEFINES_SVH
`define DQVREF_SEL_TRAINING 3'h6
`define DQVREF_SEL_SPARE 3'h7
`define DQVREF_SEL_RCW 3'h7
`define DQVREF_VALUE_LSB 0
`define DQVREF_RANGE_BIT 6
`define DQVREF_TRAIN_BIT 7
`define DQVREF_SPACING_LSB 10
`define DQVREF_FIRST_RESERVED 6'h33
`define DQVREF_STEP_BP 16'h0041
`define DQVREF_BASE_R1_BP 16'h1770
`define DQVREF_BASE_R2_BP 16'h1194
`define DQVREF_SPACING_MIN_NCK 4'h4
`define DQVREF_RST_VALUE 6'h00
`define DQVREF_RST_RANGE 1'h0
`define DQVREF_RST_TRAIN 1'h0
`define DQVREF_RST_SPACING 3'h0
`endif

/* File: rtl/dqvref_pkg.sv */
// types for the dq reference training register decode
package dqvref_pkg;
	typedef struct packed {
		logic mrs;
		logic [2:0] sel;
		logic [13:0] op;
	} dqvref_cmd_type;
	typedef struct packed {
		logic [2:0] spacing;
		logic train_en;
		logic range_sel;
		logic [5:0] value;
	} dqvref_cfg_type;
endpackage

/* File: test/dqvref_ctrl_model.sv */
// controller model issuing mode register set commands
`timescale 1ns/1ps
`default_nettype none
module dqvref_ctrl_model import dqvref_pkg::*; (
	input wire logic clk,
	output var dqvref_cmd_type cmd
);
	initial cmd = '0;
	// one-cycle command, unused address bits zero
	task automatic mrs(input logic [2:0] s, sp, input logic r, input logic [5:0] v);
		@(posedge clk) #1;
		cmd = {1'b1, s, 1'b0, sp, 2'h0, 1'b1, r, v};
		@(posedge clk) #1;
		cmd = '0;
	endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the dq reference training decode
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
	$display("BAD %0t %h %h", $time, a, b); end end
module tb import dqvref_pkg::*;;
	logic clk = 0, nrst = 0;
	dqvref_cmd_type cmd;
	dqvref_cfg_type cfg;
	logic [15:0] lvl;
	logic vld, trn;
	logic [3:0] nck;
	int fail_count = 0, checks_done = 0, cyc = 0;
	dqvref_ctrl_model u_dqvref_ctrl_model(.clk(clk), .cmd(cmd));
	dqvref_decode u_dqvref_decode(.clk(clk), .nrst(nrst), .cmd(cmd), .cfg(cfg),
		.ref_level_bp(lvl), .ref_valid(vld), .training_active(trn), .spacing_nck(nck));
	initial forever #4 clk = ~clk;
	// cycle ceiling cuts a hang short
	always @(posedge clk) if (++cyc == 2000) begin
		fail_count++;
		give_verdict();
	end
	task automatic give_verdict();
		$display("checks %0d fails %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// write, then check outputs one and two cycles on
	task automatic wr_chk(input logic [2:0] sp, input logic r, input logic [5:0] v);
		u_dqvref_ctrl_model.mrs(3'h6, sp, r, v);
		`CHK(cfg, {sp, 1'b1, r, v})
		`CHK(trn, 1'b1)
		`CHK(nck, 4'h4 + {1'b0, sp})
		@(posedge clk) #1;
		`CHK(vld, v < 6'h33)
		`CHK(lvl, v < 6'h33 ? (r ? 16'h1194 : 16'h1770) + 16'h0041 * v : 16'h0)
	endtask
	// commands to other selects leave the config unchanged
	task automatic ignored();
		dqvref_cfg_type keep;
		keep = cfg;
		for (int s = 0; s < 8; s++) if (s != 6) begin
			u_dqvref_ctrl_model.mrs(s[2:0], 3'h3, 1'b1, 6'h2a);
			`CHK(cfg, keep)
		end
	endtask
	// reset in mid-run clears the fields; range one code zero shows a cycle later
	task automatic rst_mid();
		@(posedge clk) #1;
		nrst = 0;
		@(posedge clk) #1;
		nrst = 1;
		`CHK(cfg, 11'h0)
		`CHK(trn, 1'b0)
		`CHK(nck, 4'h4)
		`CHK(vld, 1'b0)
		@(posedge clk) #1;
		`CHK(vld, 1'b1)
		`CHK(lvl, 16'h1770)
	endtask
	initial begin
		repeat (10) @(posedge clk);
		#1 nrst = 1;
		`CHK(cfg, 11'h0)
		`CHK(nck, 4'h4)
		`CHK(trn, 1'b0)
		`CHK(vld, 1'b0)
		`CHK(lvl, 16'h0000)
		for (int i = 0; i < 5; i++) wr_chk(i[2:0], i[0], 6'(i * 12));
		wr_chk(3'h4, 1'b1, 6'h32);
		wr_chk(3'h2, 1'b0, 6'h33);
		wr_chk(3'h0, 1'b1, 6'h3f);
		wr_chk(3'h1, 1'b1, 6'h00);
		ignored();
		rst_mid();
		give_verdict();
	end
endmodule
`default_nettype wire
